// >>> rtl/hmc_defs.svh
// register map, field positions, reset values and timing for the measurement control bank
`ifndef HMC_DEFS_SVH
`define HMC_DEFS_SVH

// ----------------------------------------
// register offsets (7-bit serial address)
// ----------------------------------------
`define HMC_ADDR_RESOL 7'h10
`define HMC_ADDR_CTRL1 7'h20
`define HMC_ADDR_CTRL2 7'h21
`define HMC_ADDR_CTRL3 7'h22
`define HMC_ADDR_STATUS 7'h27
`define HMC_ADDR_HUM_L 7'h28
`define HMC_ADDR_HUM_H 7'h29
`define HMC_ADDR_TMP_L 7'h2a
`define HMC_ADDR_TMP_H 7'h2b

// ----------------------------------------
// field positions
// ----------------------------------------
`define HMC_TRES_HI 4
`define HMC_TRES_LO 3
`define HMC_HRES_HI 1
`define HMC_HRES_LO 0
`define HMC_ACTIVE_BIT 7
`define HMC_HOLD_BIT 2
`define HMC_RATE_HI 1
`define HMC_RATE_LO 0
`define HMC_BOOT_BIT 7
`define HMC_ONESHOT_BIT 0
`define HMC_POL_BIT 7
`define HMC_DRIVE_BIT 6
`define HMC_PINEN_BIT 2

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define HMC_RST_BYTE 8'h00
`define HMC_RATE_ONESHOT 2'h0
`define HMC_RATE_1HZ 2'h1
`define HMC_RATE_0P2HZ 2'h2
`define HMC_TEMP_BITS_MAX 4'he
`define HMC_HUM_BITS_MAX 4'hc
`define HMC_HUM_BITS_MIN 4'h8

// ----------------------------------------
// timing
// ----------------------------------------
`define HMC_CLK_HZ 20000000
`define HMC_PERIOD_1HZ_MS 1000
`define HMC_PERIOD_0P2HZ_MS 5000
`define HMC_PERIOD_0P1HZ_MS 10000
`define HMC_TRIM_WORDS 8

`endif

// >>> rtl/hmc_pkg.sv
// types and register image decode shared by the core and the serial link
package hmc_pkg;
`include "hmc_defs.svh"

  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_IDLE = 3'b010,
    ST_CONV = 3'b100
  } hmc_state_t;

  typedef struct packed {
    logic [15:0] humidity;
    logic [15:0] temperature;
  } hmc_sample_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } hmc_link_wr_t;

  typedef struct packed {
    logic [7:0] resol;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] ctrl3;
    logic [7:0] status;
    logic [7:0] humL;
    logic [7:0] humH;
    logic [7:0] tmpL;
    logic [7:0] tmpH;
  } hmc_image_t;

  // unmapped addresses read as zero
  function automatic logic [7:0] hmc_read_byte(input hmc_image_t img, input logic [6:0] addr);
    logic [7:0] val;
    val = 8'h00;
    case (addr)
      `HMC_ADDR_RESOL: val = img.resol;
      `HMC_ADDR_CTRL1: val = img.ctrl1;
      `HMC_ADDR_CTRL2: val = img.ctrl2;
      `HMC_ADDR_CTRL3: val = img.ctrl3;
      `HMC_ADDR_STATUS: val = img.status;
      `HMC_ADDR_HUM_L: val = img.humL;
      `HMC_ADDR_HUM_H: val = img.humH;
      `HMC_ADDR_TMP_L: val = img.tmpL;
      `HMC_ADDR_TMP_H: val = img.tmpH;
      default: val = 8'h00;
    endcase
    return val;
  endfunction
endpackage

// >>> rtl/hmc_serial_link.sv
// 3-wire serial slave on the link clock: command byte, then data bytes with address increment
`timescale 1ns/1ps
module hmc_serial_link (
  input wire logic serial_clock,
  input wire logic serial_select_n,
  input wire logic rst,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  input wire hmc_pkg::hmc_image_t image,
  output hmc_pkg::hmc_link_wr_t wrBundle,
  output logic wrToggle,
  output logic [6:0] rdAddr,
  output logic rdToggle
);
  // ----------------------------------------
  // frame state, cleared whenever select is high
  // ----------------------------------------
  logic [2:0] bitCnt_ff;
  logic cmdDone_ff;
  logic isRead_ff;
  logic [6:0] shift_ff;
  logic [6:0] curAddr_ff;

  // select high resets the frame; the clock stands still between frames
  wire linkRst = rst | serial_select_n;
  wire [7:0] inByte = {shift_ff, sdioIn};
  wire byteEnd = (bitCnt_ff == 3'h7);
  wire [7:0] rdByte = hmc_pkg::hmc_read_byte(image, curAddr_ff);

  // sample on rising edge, first byte is read flag plus address
  always_ff @(posedge serial_clock or posedge linkRst) begin
    if (linkRst) begin
      bitCnt_ff <= 3'h0;
      cmdDone_ff <= 1'b0;
      isRead_ff <= 1'b0;
      shift_ff <= 7'h00;
      curAddr_ff <= 7'h00;
    end else begin
      bitCnt_ff <= bitCnt_ff + 3'h1;
      shift_ff <= inByte[6:0];
      if (byteEnd && !cmdDone_ff) begin
        cmdDone_ff <= 1'b1;
        isRead_ff <= inByte[7];
        curAddr_ff <= inByte[6:0];
      end else if (byteEnd) begin
        curAddr_ff <= curAddr_ff + 7'h01;
      end
    end
  end

  // events survive the frame end, so only the chip reset clears them
  always_ff @(posedge serial_clock or posedge rst) begin
    if (rst) begin
      wrBundle <= '0;
      wrToggle <= 1'b0;
      rdAddr <= 7'h00;
      rdToggle <= 1'b0;
    end else if (byteEnd && cmdDone_ff) begin
      if (isRead_ff) begin
        rdAddr <= curAddr_ff;
        rdToggle <= ~rdToggle;
      end else begin
        wrBundle <= '{addr: curAddr_ff, data: inByte};
        wrToggle <= ~wrToggle;
      end
    end
  end

  // drive read data on falling edge, msb first
  always_ff @(negedge serial_clock or posedge linkRst) begin
    if (linkRst) begin
      sdioOut <= 1'b0;
      sdioOe <= 1'b0;
    end else if (cmdDone_ff && isRead_ff) begin
      sdioOe <= 1'b1;
      sdioOut <= rdByte[~bitCnt_ff];
    end
  end
endmodule // hmc_serial_link

// >>> rtl/hmc_measure_ctrl.sv
// measurement control and result register bank of the humidity and temperature sensor
`timescale 1ns/1ps
`include "hmc_defs.svh"

// How it works
// - temperature resolution from resolution bits 4:3
// - humidity resolution from resolution bits 1:0
// - control one bit 7 selects active mode
// - hold bit freezes results until both bytes read
// - rate field picks one-shot or periodic rate
// - boot bit reloads trim, then self-clears
// - trim copy runs automatically after power-up
// - one-shot bit starts one combined acquisition
// - conversion end loads results, sets flags, clears
// - ready pin polarity bit, default active high
// - ready pin drive bit, push-pull or open-drain
// - ready pin enable bit, default disabled
// - ready pin active on either flag set
// - pin inactive only after both high bytes read
// - status updates on every completed acquisition
// - humidity flag set on sample, cleared reading 29h
// - temperature flag set on sample, cleared reading 2bh
// - humidity result bytes at 28h and 29h
// - temperature result bytes at 2ah and 2bh
// - sixteen clock access, more for longer bursts
// - drive on falling edge, sample on rising
module hmc_measure_ctrl #(
  parameter int unsigned PERIOD_1HZ_CYC = `HMC_PERIOD_1HZ_MS * (`HMC_CLK_HZ / 1000),
  parameter int unsigned PERIOD_0P2HZ_CYC = `HMC_PERIOD_0P2HZ_MS * (`HMC_CLK_HZ / 1000),
  parameter int unsigned PERIOD_0P1HZ_CYC = `HMC_PERIOD_0P1HZ_MS * (`HMC_CLK_HZ / 1000)
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic serial_clock,
  input wire logic serial_select_n,
  input wire logic sdioIn,
  output logic sdioOut,
  output logic sdioOe,
  output logic convStart,
  input wire logic convDone,
  input wire hmc_pkg::hmc_sample_t convResult,
  output logic [1:0] tempResolutionSel,
  output logic [1:0] humidityResolutionSel,
  output logic [3:0] tempResolutionBits,
  output logic [3:0] humidityResolutionBits,
  output logic trimCopyActive,
  output logic [2:0] trimWordIdx,
  output logic resultReadyPinOut,
  output logic resultReadyPinOe
);
  localparam logic [27:0] PERIOD_1HZ_LAST = 28'(PERIOD_1HZ_CYC - 1);
  localparam logic [27:0] PERIOD_0P2HZ_LAST = 28'(PERIOD_0P2HZ_CYC - 1);
  localparam logic [27:0] PERIOD_0P1HZ_LAST = 28'(PERIOD_0P1HZ_CYC - 1);
  localparam logic [2:0] TRIM_LAST = 3'(`HMC_TRIM_WORDS - 1);

  // resolution code to bit count, shared by both quantities
  function automatic logic [3:0] resBits(input logic isTemp, input logic [1:0] code);
    logic [3:0] bits;
    bits = 4'h0;
    if (isTemp) begin
      bits = `HMC_TEMP_BITS_MAX - {2'h0, code};
    end else if (code == 2'h3) begin
      bits = `HMC_HUM_BITS_MIN;
    end else begin
      bits = `HMC_HUM_BITS_MAX - {2'h0, code};
    end
    return bits;
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [2:0] selSync_ff;
  logic [2:0] wrSync_ff;
  logic [2:0] rdSync_ff;
  logic selAcc_ff;
  logic wrAcc_ff;
  logic rdAcc_ff;
  logic wrToggle;
  logic rdToggle;
  logic [6:0] rdAddrLink;
  hmc_pkg::hmc_link_wr_t wrBundle;
  hmc_pkg::hmc_image_t image_ff;
  hmc_pkg::hmc_image_t liveImage;
  logic [7:0] resol_ff;
  logic [7:0] ctrl1_ff;
  logic [7:0] ctrl3_ff;
  logic [5:0] ctrl2Rsv_ff;
  logic boot_ff;
  logic oneShot_ff;
  logic nxt_boot;
  logic nxt_oneShot;
  hmc_pkg::hmc_state_t state_ff;
  hmc_pkg::hmc_state_t nxt_state;
  logic [2:0] trimIdx_ff;
  logic convStart_ff;
  logic shotConv_ff;
  logic [27:0] periodCnt_ff;
  logic tickPend_ff;
  logic [1:0][15:0] sample_ff;
  logic [1:0][15:0] result_ff;
  logic [1:0] pend_ff;
  logic [1:0] lowSeen_ff;
  logic [1:0] highSeen_ff;
  logic [1:0] flag_ff;
  logic [3:0] tempBits_ff;
  logic [3:0] humBits_ff;
  logic readyOut_ff;
  logic readyOe_ff;

  // ----------------------------------------
  // serial link and domain crossing
  // ----------------------------------------
  hmc_serial_link u_link (
    .serial_clock(serial_clock),
    .serial_select_n(serial_select_n),
    .rst(rst),
    .sdioIn(sdioIn),
    .sdioOut(sdioOut),
    .sdioOe(sdioOe),
    .image(image_ff),
    .wrBundle(wrBundle),
    .wrToggle(wrToggle),
    .rdAddr(rdAddrLink),
    .rdToggle(rdToggle)
  );

  // three-stage synchronisers, stage 0 feeds only stage 1
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      selSync_ff <= 3'h7;
      wrSync_ff <= 3'h0;
      rdSync_ff <= 3'h0;
    end else begin
      selSync_ff <= {selSync_ff[1:0], serial_select_n};
      wrSync_ff <= {wrSync_ff[1:0], wrToggle};
      rdSync_ff <= {rdSync_ff[1:0], rdToggle};
    end
  end

  // a change counts once stages two and three agree
  wire selAgree = (selSync_ff[1] == selSync_ff[2]);
  wire wrAgree = (wrSync_ff[1] == wrSync_ff[2]);
  wire rdAgree = (rdSync_ff[1] == rdSync_ff[2]);
  wire wrEv = wrAgree && (wrSync_ff[2] != wrAcc_ff);
  wire rdEv = rdAgree && (rdSync_ff[2] != rdAcc_ff);
  wire frameIdle = selAcc_ff && selAgree && selSync_ff[2];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      selAcc_ff <= 1'b1;
      wrAcc_ff <= 1'b0;
      rdAcc_ff <= 1'b0;
    end else begin
      selAcc_ff <= selAgree ? selSync_ff[2] : selAcc_ff;
      wrAcc_ff <= wrAgree ? wrSync_ff[2] : wrAcc_ff;
      rdAcc_ff <= rdAgree ? rdSync_ff[2] : rdAcc_ff;
    end
  end

  // image stays frozen while a frame runs, so the link reads it quasi-statically
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      image_ff <= '0;
    end else if (frameIdle) begin
      image_ff <= liveImage;
    end
  end

  // ----------------------------------------
  // register access decode
  // ----------------------------------------
  wire wrResol = wrEv && (wrBundle.addr == `HMC_ADDR_RESOL);
  wire wrCtrl1 = wrEv && (wrBundle.addr == `HMC_ADDR_CTRL1);
  wire wrCtrl2 = wrEv && (wrBundle.addr == `HMC_ADDR_CTRL2);
  wire wrCtrl3 = wrEv && (wrBundle.addr == `HMC_ADDR_CTRL3);
  wire setBoot = wrCtrl2 && wrBundle.data[`HMC_BOOT_BIT];
  wire setShot = wrCtrl2 && wrBundle.data[`HMC_ONESHOT_BIT];
  // index 1 is humidity, index 0 is temperature
  wire [1:0] rdLow = {rdEv && (rdAddrLink == `HMC_ADDR_HUM_L),
                      rdEv && (rdAddrLink == `HMC_ADDR_TMP_L)};
  wire [1:0] rdHigh = {rdEv && (rdAddrLink == `HMC_ADDR_HUM_H),
                       rdEv && (rdAddrLink == `HMC_ADDR_TMP_H)};

  // control fields
  wire activeSel = ctrl1_ff[`HMC_ACTIVE_BIT];
  wire holdSel = ctrl1_ff[`HMC_HOLD_BIT];
  wire [1:0] rateSel = ctrl1_ff[`HMC_RATE_HI:`HMC_RATE_LO];
  wire pinPol = ctrl3_ff[`HMC_POL_BIT];
  wire pinOd = ctrl3_ff[`HMC_DRIVE_BIT];
  wire pinEn = ctrl3_ff[`HMC_PINEN_BIT];

  // reserved bits are stored as written and read back
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      resol_ff <= `HMC_RST_BYTE;
      ctrl1_ff <= `HMC_RST_BYTE;
      ctrl3_ff <= `HMC_RST_BYTE;
      ctrl2Rsv_ff <= 6'h00;
    end else begin
      if (wrResol) resol_ff <= wrBundle.data;
      if (wrCtrl1) ctrl1_ff <= wrBundle.data;
      if (wrCtrl3) ctrl3_ff <= wrBundle.data;
      if (wrCtrl2) ctrl2Rsv_ff <= wrBundle.data[6:1];
    end
  end

  // ----------------------------------------
  // sequencer: trim copy, idle, conversion
  // ----------------------------------------
  wire inBoot = (state_ff == hmc_pkg::ST_BOOT);
  wire trimLast = (trimIdx_ff == TRIM_LAST);
  wire bootDone = inBoot && trimLast;
  wire convFinish = (state_ff == hmc_pkg::ST_CONV) && convDone;
  wire shotDone = convFinish && shotConv_ff;
  // boot request takes precedence over a conversion start
  wire startConv = (state_ff == hmc_pkg::ST_IDLE) && !boot_ff && activeSel
                   && (oneShot_ff || tickPend_ff);

  // set wins over the hardware clear for both self-clearing bits
  assign nxt_boot = setBoot | (boot_ff & ~bootDone);
  assign nxt_oneShot = setShot | (oneShot_ff & ~shotDone);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      hmc_pkg::ST_BOOT: begin
        if (trimLast) nxt_state = hmc_pkg::ST_IDLE;
      end
      hmc_pkg::ST_IDLE: begin
        if (boot_ff) begin
          nxt_state = hmc_pkg::ST_BOOT;
        end else if (startConv) begin
          nxt_state = hmc_pkg::ST_CONV;
        end
      end
      hmc_pkg::ST_CONV: begin
        if (convDone) nxt_state = hmc_pkg::ST_IDLE;
      end
    endcase
  end

  // reset lands in the trim copy, so power-up reload needs no software
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= hmc_pkg::ST_BOOT;
      trimIdx_ff <= 3'h0;
      boot_ff <= 1'b0;
      oneShot_ff <= 1'b0;
      convStart_ff <= 1'b0;
      shotConv_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      trimIdx_ff <= inBoot ? trimIdx_ff + 3'h1 : 3'h0;
      boot_ff <= nxt_boot;
      oneShot_ff <= nxt_oneShot;
      convStart_ff <= startConv;
      shotConv_ff <= startConv ? oneShot_ff : shotConv_ff;
    end
  end

  // ----------------------------------------
  // periodic acquisition timer
  // ----------------------------------------
  wire [27:0] periodLast = (rateSel == `HMC_RATE_1HZ) ? PERIOD_1HZ_LAST :
                           (rateSel == `HMC_RATE_0P2HZ) ? PERIOD_0P2HZ_LAST :
                           PERIOD_0P1HZ_LAST;
  wire periodRun = activeSel && (rateSel != `HMC_RATE_ONESHOT) && !inBoot;
  wire periodTick = periodRun && (periodCnt_ff == periodLast);

  // a tick that lands mid-conversion waits instead of being lost
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      periodCnt_ff <= 28'h0000000;
      tickPend_ff <= 1'b0;
    end else begin
      periodCnt_ff <= (!periodRun || periodTick) ? 28'h0000000 : periodCnt_ff + 28'h0000001;
      tickPend_ff <= periodTick | (tickPend_ff & periodRun & ~startConv);
    end
  end

  // ----------------------------------------
  // results, hold-until-read and flags
  // ----------------------------------------
  wire [1:0] resLocked = {2{holdSel}} & ~(lowSeen_ff & highSeen_ff);
  wire [1:0] pendGo = pend_ff & ~resLocked;

  // pending sample copies across once the output pair is released
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sample_ff <= '0;
      result_ff <= '0;
      pend_ff <= 2'h0;
      lowSeen_ff <= 2'h3;
      highSeen_ff <= 2'h3;
    end else begin
      if (convFinish) sample_ff <= {convResult.humidity, convResult.temperature};
      pend_ff <= {2{convFinish}} | (pend_ff & ~pendGo);
      for (int q = 0; q < 2; q++) begin
        if (pendGo[q]) begin
          result_ff[q] <= sample_ff[q];
          lowSeen_ff[q] <= ~holdSel;
          highSeen_ff[q] <= ~holdSel;
        end else begin
          if (rdLow[q]) lowSeen_ff[q] <= 1'b1;
          if (rdHigh[q]) highSeen_ff[q] <= 1'b1;
        end
      end
    end
  end

  // flags ignore the hold bit; a new sample wins over a clearing read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_ff <= 2'h0;
    end else begin
      flag_ff <= {2{convFinish}} | (flag_ff & ~rdHigh);
    end
  end

  // readable image of every mapped register
  assign liveImage = '{
    resol: resol_ff,
    ctrl1: ctrl1_ff,
    ctrl2: {boot_ff, ctrl2Rsv_ff, oneShot_ff},
    ctrl3: ctrl3_ff,
    status: {6'h00, flag_ff},
    humL: result_ff[1][7:0],
    humH: result_ff[1][15:8],
    tmpL: result_ff[0][7:0],
    tmpH: result_ff[0][15:8]
  };

  // ----------------------------------------
  // ready pin and front-end settings
  // ----------------------------------------
  wire pinActive = pinEn && (|flag_ff);
  wire pinLevel = pinActive ^ pinPol;

  // open drain only ever pulls low, never drives high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      readyOut_ff <= 1'b0;
      readyOe_ff <= 1'b1;
      tempBits_ff <= `HMC_TEMP_BITS_MAX;
      humBits_ff <= `HMC_HUM_BITS_MAX;
    end else begin
      readyOut_ff <= pinOd ? 1'b0 : pinLevel;
      readyOe_ff <= pinOd ? ~pinLevel : 1'b1;
      tempBits_ff <= resBits(1'b1, resol_ff[`HMC_TRES_HI:`HMC_TRES_LO]);
      humBits_ff <= resBits(1'b0, resol_ff[`HMC_HRES_HI:`HMC_HRES_LO]);
    end
  end

  // outputs
  assign convStart = convStart_ff;
  assign tempResolutionSel = resol_ff[`HMC_TRES_HI:`HMC_TRES_LO];
  assign humidityResolutionSel = resol_ff[`HMC_HRES_HI:`HMC_HRES_LO];
  assign tempResolutionBits = tempBits_ff;
  assign humidityResolutionBits = humBits_ff;
  assign trimCopyActive = inBoot;
  assign trimWordIdx = trimIdx_ff;
  assign resultReadyPinOut = readyOut_ff;
  assign resultReadyPinOe = readyOe_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_hum_flag_clear: assert property (rdHigh[1] && !convFinish |=> !flag_ff[1])
    else $error("humidity flag not cleared by high byte read");
  a_tmp_flag_clear: assert property (rdHigh[0] && !convFinish |=> !flag_ff[0])
    else $error("temperature flag not cleared by high byte read");
  a_done_sets_flags: assert property (convFinish |=> flag_ff == 2'h3)
    else $error("conversion end did not set both flags");
  a_shot_self_clear: assert property (shotDone && !setShot |=> !oneShot_ff)
    else $error("one-shot bit not cleared after conversion");
  a_pdown_no_start: assert property (convStart_ff |-> $past(activeSel))
    else $error("conversion started in power-down");
  a_boot_length: assert property ($rose(inBoot) |-> inBoot [*8] ##1 !inBoot)
    else $error("trim copy length wrong");
  a_boot_clear: assert property (bootDone && !setBoot |=> !boot_ff)
    else $error("boot bit not cleared after copy");
  a_hold_keeps: assert property (resLocked[1] |=> $stable(result_ff[1]))
    else $error("held humidity result changed");
  a_cont_update: assert property ((convFinish && !holdSel && !pend_ff[1]) ##1 !holdSel
    |=> result_ff[1] == $past(convResult.humidity, 2))
    else $error("continuous update missed");
  a_period_start: assert property (periodTick && state_ff == hmc_pkg::ST_IDLE && !boot_ff
    && !oneShot_ff |-> ##2 convStart_ff)
    else $error("period tick did not start conversion");
  a_pin_push: assert property (pinEn && !pinOd && !pinPol && (|flag_ff)
    |=> resultReadyPinOut && resultReadyPinOe)
    else $error("ready pin not active with flag set");
  a_pin_od_low: assert property (pinOd |=> !resultReadyPinOut)
    else $error("open drain pin drove high");
  a_pin_off: assert property (!pinEn && !pinOd |=> resultReadyPinOut == $past(pinPol))
    else $error("disabled ready pin not inactive");
  a_hum_bits: assert property (resol_ff[1:0] == 2'h3 |=> humidityResolutionBits == 4'h8)
    else $error("humidity resolution decode wrong");

  c_one_shot: cover property (shotDone);
  c_period: cover property (periodTick ##2 convStart_ff);
  c_reboot: cover property (setBoot ##[1:4] $rose(inBoot));
  c_held: cover property (resLocked[1] && pend_ff[1]);
endmodule // hmc_measure_ctrl

// >>> test/hmc_host_model.sv
// serial bus master model that reaches the register bank over the 3-wire link
`timescale 1ns/1ps
module hmc_host_model (
  output logic serial_clock,
  output logic serial_select_n,
  output logic sdioIn,
  input wire logic sdioOut,
  input wire logic sdioOe
);
  logic bitv;
  // released line shows the inverse of the last host bit, never a stale value
  assign sdioIn = sdioOe ? sdioOut : bitv;
  // clock idles high outside frames
  initial begin
    serial_clock = 1'b1;
    serial_select_n = 1'b1;
    bitv = 1'b1;
  end
  // one 16-clock access: command byte, then one data byte
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {rw, a, wd};
    rd = 8'h00;
    serial_select_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      #40 serial_clock = 1'b0;
      bitv = (i < 8 || !rw) ? sh[15-i] : ~bitv;
      #40 serial_clock = 1'b1;
      if (i >= 8) rd = {rd[6:0], sdioIn};
    end
    // gap lets the write land and the read image refresh
    #40 serial_select_n = 1'b1;
    #300;
  endtask
endmodule // hmc_host_model

// >>> test/hmc_measure_ctrl_test.sv
// self-checking bench for the measurement control bank
`timescale 1ns/1ps
module hmc_measure_ctrl_test;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic serial_clock, serial_select_n, sdioIn, sdioOut, sdioOe, convStart;
  logic convDone = 1'b0;
  hmc_pkg::hmc_sample_t convResult = {16'h6350, 16'h1234};
  logic [1:0] tempResolutionSel, humidityResolutionSel;
  logic [3:0] tempResolutionBits, humidityResolutionBits;
  logic trimCopyActive, resultReadyPinOut, resultReadyPinOe;
  logic [2:0] trimWordIdx;
  logic [2:0] feCnt = 3'h0;
  logic [7:0] rdv;
  logic [6:0] zeroA [6] = '{7'h10, 7'h20, 7'h21, 7'h22, 7'h27, 7'h30};
  logic [3:0] hTab [4] = '{4'hc, 4'hb, 4'ha, 4'h8};
  int startCnt = 0;
  int n = 0;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  always #25 core_clk = ~core_clk;
  hmc_measure_ctrl #(.PERIOD_1HZ_CYC(60), .PERIOD_0P2HZ_CYC(100), .PERIOD_0P1HZ_CYC(200))
  u_dut (.core_clk, .rst, .serial_clock, .serial_select_n, .sdioIn, .sdioOut, .sdioOe,
    .convStart, .convDone, .convResult, .tempResolutionSel, .humidityResolutionSel,
    .tempResolutionBits, .humidityResolutionBits, .trimCopyActive, .trimWordIdx,
    .resultReadyPinOut, .resultReadyPinOe);
  hmc_host_model u_host (.serial_clock, .serial_select_n, .sdioIn, .sdioOut, .sdioOe);
  // front end answers each start four cycles later, so no start is lost
  always @(negedge core_clk) begin
    convDone <= (feCnt == 3'h1);
    if (convStart === 1'b1) begin
      feCnt <= 3'h4;
      startCnt <= startCnt + 1;
    end else if (feCnt != 3'h0) feCnt <= feCnt - 3'h1;
  end
  // hang guard, far above the expected run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, rdv);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    u_host.xfer(1'b1, a, 8'h00, rdv);
    chk($sformatf("reg %h", a), exp, rdv);
  endtask
  task automatic pin(input logic o, input logic e);
    repeat (20) @(negedge core_clk);
    chk("ready pin", {6'h0, o, e}, {6'h0, resultReadyPinOut, resultReadyPinOe});
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(negedge core_clk);
    chk("trim in reset", 8'h01, {7'h0, trimCopyActive});
    rst = 1'b0;
    // seven edges after release the copy is on its last word
    repeat (7) @(negedge core_clk);
    chk("trim word", 8'h07, {5'h0, trimWordIdx});
    repeat (5) @(negedge core_clk);
    chk("trim after reset", 8'h00, {7'h0, trimCopyActive});
    wr(7'h30, 8'hff);
    for (int i = 0; i < 6; i++) rd(zeroA[i], 8'h00);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      wr(7'h10, {3'h0, 2'(c), 1'b0, 2'(c)});
      chk("temp bits", {4'h0, 4'(14 - c)}, {4'h0, tempResolutionBits});
      chk("hum bits", {4'h0, hTab[c]}, {4'h0, humidityResolutionBits});
      chk("sel", {4'h0, 2'(c), 2'(c)}, {4'h0, tempResolutionSel, humidityResolutionSel});
    end
    rd(7'h10, 8'h1b);
    wr(7'h21, 8'h80);
    chk("boot copy", 8'h01, {7'h0, trimCopyActive});
    repeat (12) @(negedge core_clk);
    rd(7'h21, 8'h00);
    $display("test config done");
    wr(7'h22, 8'h04);
    pin(1'b0, 1'b1);
    wr(7'h21, 8'h01);
    repeat (20) @(negedge core_clk);
    chk("start in power-down", 8'h00, 8'(startCnt));
    wr(7'h20, 8'h80);
    pin(1'b1, 1'b1);
    chk("starts", 8'h01, 8'(startCnt));
    rd(7'h27, 8'h03);
    rd(7'h21, 8'h00);
    wr(7'h28, 8'hff);
    rd(7'h28, 8'h50);
    rd(7'h29, 8'h63);
    pin(1'b1, 1'b1);
    rd(7'h27, 8'h01);
    rd(7'h2a, 8'h34);
    rd(7'h2b, 8'h12);
    pin(1'b0, 1'b1);
    rd(7'h27, 8'h00);
    wr(7'h22, 8'h84);
    pin(1'b1, 1'b1);
    // open drain pulls an inactive-low level, releases an inactive-high one
    wr(7'h22, 8'h44);
    pin(1'b0, 1'b1);
    wr(7'h22, 8'hc4);
    pin(1'b0, 1'b0);
    $display("test single shot done");
    // hold on: second sample waits until both bytes of the first are read
    wr(7'h20, 8'h84);
    wr(7'h21, 8'h01);
    repeat (20) @(negedge core_clk);
    convResult = {16'h1a2b, 16'h3c4d};
    wr(7'h21, 8'h01);
    repeat (20) @(negedge core_clk);
    rd(7'h27, 8'h03);
    rd(7'h28, 8'h50);
    rd(7'h29, 8'h63);
    rd(7'h28, 8'h2b);
    rd(7'h29, 8'h1a);
    rd(7'h2a, 8'h34);
    $display("test hold done");
    for (int c = 1; c < 4; c++) begin
      n = startCnt;
      wr(7'h20, 8'h80 | 8'(c));
      repeat (230) @(negedge core_clk);
      chk("periodic starts", 8'(4 - c), 8'(startCnt - n));
      wr(7'h20, 8'h00);
    end
    $display("test periodic done");
    complete_run();
  end
endmodule // hmc_measure_ctrl_test
